// ===== rtl/bbd_pkg.sv
package bbd_pkg;
  // ----------------------------------------
  // instruction encoding
  // ----------------------------------------
  localparam int          PC_W          = 21;
  localparam logic [4:0]  OP_BRANCH     = 5'h1A;
  localparam logic [3:0]  OP_BITSET     = 4'h8;
  localparam int          BR_OFS_MSB    = 10;
  localparam int          OP_BRANCH_LSB = 11;
  localparam int          OP_BITSET_LSB = 12;
  localparam int          FILE_ADR_W    = 8;
  localparam int          BIT_IDX_LSB   = 9;
  localparam int          ACC_BIT_POS   = 8;
  localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
  localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
  localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET  = 21'h000000;

  typedef enum logic [1:0] {
    BBD_EXEC  = 2'b00,
    BBD_FLUSH = 2'b01
  } bbd_state_e;

  // data-memory request towards the register file
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } bbd_mem_s;
endpackage

// ===== rtl/bbd_core.sv
`timescale 1ns/100ps
// Summary of operation
// - branch opcode 11010, eleven-bit offset, flags untouched
// - offset is signed -1024 to +1023
// - new pc is pc plus two plus 2n
// - branch takes two cycles, second is nop
// - bit-set 1000 forces bit, one cycle, no flags
// - access bit zero: access bank, one: bank select
// - extended set, a=0, f<=5Fh: indexed literal offset
module bbd_core (
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_in,
  input  wire logic                      instr_valid_in,
  input  wire logic [15:0]               instr_in,
  input  wire logic [3:0]                bank_select_register_in,
  input  wire logic                      ext_set_en_in,
  input  wire logic [11:0]               index_base_in,
  input  wire logic [7:0]                mem_rdata_in,
  output logic      [bbd_pkg::PC_W-1:0]  pc_out,
  output logic                           flush_out,
  output logic                           status_we_out,
  output bbd_pkg::bbd_mem_s              mem_out
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  bbd_pkg::bbd_state_e state_ff, nxt_state;
  logic [bbd_pkg::PC_W-1:0] pc_ff, nxt_pc;
  logic                     flush_ff;
  bbd_pkg::bbd_mem_s        mem_ff, nxt_mem;

  // a word seen in the flush cycle came from the fall-through address, so it never executes
  wire logic executing = instr_valid_in && (state_ff == bbd_pkg::BBD_EXEC);
  wire logic is_branch = executing && (instr_in[15:bbd_pkg::OP_BRANCH_LSB] == bbd_pkg::OP_BRANCH);
  wire logic is_bitset = executing && (instr_in[15:bbd_pkg::OP_BITSET_LSB] == bbd_pkg::OP_BITSET);
  wire logic signed [10:0] br_ofs = instr_in[bbd_pkg::BR_OFS_MSB:0];
  // the offset counts words: sign-extend it to the pc width and double it
  wire logic [bbd_pkg::PC_W-1:0] br_ofs_x2 =
    {{(bbd_pkg::PC_W-bbd_pkg::BR_OFS_MSB-2){br_ofs[bbd_pkg::BR_OFS_MSB]}}, br_ofs, 1'b0};
  wire logic [bbd_pkg::PC_W-1:0] br_target = pc_ff + bbd_pkg::PC_STEP + br_ofs_x2;
  wire logic [2:0] bit_idx  = instr_in[bbd_pkg::BIT_IDX_LSB +: 3];
  wire logic       acc_bit  = instr_in[bbd_pkg::ACC_BIT_POS];
  wire logic [7:0] file_adr = instr_in[bbd_pkg::FILE_ADR_W-1:0];
  // indexed mode adds the literal to the index pointer
  wire logic       use_index = !acc_bit && ext_set_en_in && (file_adr <= bbd_pkg::IDX_LIMIT);
  wire logic [11:0] idx_addr = index_base_in + {4'h0, file_adr};
  // access bank: low half maps to bank 0, upper half to the top bank
  wire logic [11:0] acc_addr = file_adr[bbd_pkg::FILE_ADR_W-1] ? {bbd_pkg::ACCESS_HI_BNK, file_adr}
                                                               : {bbd_pkg::ACCESS_LO_BNK, file_adr};
  wire logic [11:0] bank_addr = {bank_select_register_in, file_adr};
  wire logic [11:0] bs_addr = use_index ? idx_addr :
                              (acc_bit ? bank_addr : acc_addr);
  wire logic [7:0]  set_mask = 8'h01 << bit_idx;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_state = bbd_pkg::BBD_EXEC;
    nxt_pc    = pc_ff;
    nxt_mem   = '0;
    case (state_ff)
      bbd_pkg::BBD_EXEC: begin
        if (is_branch) begin
          nxt_pc    = br_target;
          nxt_state = bbd_pkg::BBD_FLUSH;
        end else if (instr_valid_in) begin
          nxt_pc = pc_ff + bbd_pkg::PC_STEP;
        end
        // limitation: mem_rdata_in must already hold the target register in this cycle;
        // that buys a single-cycle read-modify-write with no second pipeline stage
        if (is_bitset) begin
          nxt_mem.rd    = 1'b1;
          nxt_mem.wr    = 1'b1;
          nxt_mem.addr  = bs_addr;
          nxt_mem.wdata = mem_rdata_in | set_mask;
        end
      end
      bbd_pkg::BBD_FLUSH: begin
        nxt_state = bbd_pkg::BBD_EXEC;
      end
      default: nxt_state = bbd_pkg::BBD_EXEC;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= bbd_pkg::BBD_EXEC;
      pc_ff    <= bbd_pkg::PC_RESET;
      flush_ff <= 1'b0;
      mem_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      flush_ff <= is_branch;
      mem_ff   <= nxt_mem;
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  // neither instruction writes status flags; the port stays so a wider decoder can drive it
  logic status_we_ff;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      status_we_ff <= 1'b0;
    end else begin
      status_we_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pc_out        = pc_ff;
  assign flush_out     = flush_ff;
  assign mem_out       = mem_ff;
  assign status_we_out = status_we_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_branch_target;
    @(posedge clk_sys_in) disable iff (rst_in)
      is_branch |=> pc_ff == $past(pc_ff) + bbd_pkg::PC_STEP + $past(br_ofs_x2);
  endproperty
  a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

  property p_branch_two_cycles;
    @(posedge clk_sys_in) disable iff (rst_in)
      is_branch |=> state_ff == bbd_pkg::BBD_FLUSH ##1 state_ff == bbd_pkg::BBD_EXEC;
  endproperty
  a_branch_two_cycles: assert property (p_branch_two_cycles) else $error("branch not two cycles");

  property p_flush;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state_ff == bbd_pkg::BBD_FLUSH) |-> flush_out && !mem_out.wr ##1 !flush_out || is_branch;
  endproperty
  a_flush: assert property (p_flush) else $error("prefetch not discarded");

  property p_no_flags;
    @(posedge clk_sys_in) disable iff (rst_in)
      (is_branch || is_bitset) |=> !status_we_out;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("status written");

  property p_bitset_one;
    @(posedge clk_sys_in) disable iff (rst_in)
      is_bitset |=> mem_out.wr && mem_out.wdata[$past(bit_idx)]
                    && (mem_out.wdata | $past(set_mask)) == ($past(mem_rdata_in) | $past(set_mask));
  endproperty
  a_bitset_one: assert property (p_bitset_one) else $error("bit not set");

  property p_bank_sel;
    @(posedge clk_sys_in) disable iff (rst_in)
      (is_bitset && acc_bit) |=> mem_out.addr == {$past(bank_select_register_in), $past(file_adr)};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select address wrong");

  property p_indexed;
    @(posedge clk_sys_in) disable iff (rst_in)
      (is_bitset && !acc_bit && ext_set_en_in && file_adr <= bbd_pkg::IDX_LIMIT)
        |=> mem_out.addr == $past(index_base_in) + {4'h0, $past(file_adr)};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_neg_ofs;
    @(posedge clk_sys_in) disable iff (rst_in)
      (is_branch && br_ofs < 0) |=> pc_ff < $past(pc_ff) + bbd_pkg::PC_STEP || $past(pc_ff) < 21'h000800;
  endproperty
  a_neg_ofs: assert property (p_neg_ofs) else $error("offset sign wrong");

  // ----------------------------------------
  // checks: sequencing
  // ----------------------------------------
  property p_seq_pc;
    @(posedge clk_sys_in) disable iff (rst_in)
      (executing && !is_branch) |=> pc_ff == $past(pc_ff) + bbd_pkg::PC_STEP;
  endproperty
  a_seq_pc: assert property (p_seq_pc) else $error("sequential pc step wrong");

  property p_idle_pc;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!instr_valid_in && state_ff == bbd_pkg::BBD_EXEC) |=> pc_ff == $past(pc_ff) && !flush_out;
  endproperty
  a_idle_pc: assert property (p_idle_pc) else $error("pc moved without an instruction");

  property p_flush_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state_ff == bbd_pkg::BBD_FLUSH) |=> pc_ff == $past(pc_ff);
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("pc moved in flush cycle");

  property p_flush_pulse;
    @(posedge clk_sys_in) disable iff (rst_in)
      flush_out |=> !flush_out;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than one cycle");

  // ----------------------------------------
  // checks: bit-set addressing
  // ----------------------------------------
  property p_wr_only_bitset;
    @(posedge clk_sys_in) disable iff (rst_in)
      !is_bitset |=> !mem_out.wr && !mem_out.rd;
  endproperty
  a_wr_only_bitset: assert property (p_wr_only_bitset) else $error("memory access without bit-set");

  property p_access_low;
    @(posedge clk_sys_in) disable iff (rst_in)
      (is_bitset && !acc_bit && !file_adr[bbd_pkg::FILE_ADR_W-1]
        && !(ext_set_en_in && file_adr <= bbd_pkg::IDX_LIMIT))
        |=> mem_out.addr == {bbd_pkg::ACCESS_LO_BNK, $past(file_adr)};
  endproperty
  a_access_low: assert property (p_access_low) else $error("low access bank address wrong");

  property p_access_high;
    @(posedge clk_sys_in) disable iff (rst_in)
      (is_bitset && !acc_bit && file_adr[bbd_pkg::FILE_ADR_W-1])
        |=> mem_out.addr == {bbd_pkg::ACCESS_HI_BNK, $past(file_adr)};
  endproperty
  a_access_high: assert property (p_access_high) else $error("high access bank address wrong");
endmodule

// ===== verif/tb_branch_bitset_decode.sv
`timescale 1ns/100ps
module tb_branch_bitset_decode;
  logic                     clk_sys_in, rst_in, instr_valid_in, ext_set_en_in;
  logic [15:0]              instr_in;
  logic [3:0]               bank_select_register_in;
  logic [11:0]              index_base_in;
  logic [7:0]               mem_rdata_in;
  logic [bbd_pkg::PC_W-1:0] pc_out, exp_pc;
  logic                     flush_out, status_we_out;
  bbd_pkg::bbd_mem_s        mem_out;
  int                       n_mismatch, cmp_count, cycles;

  bbd_core uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .bank_select_register_in(bank_select_register_in),
    .ext_set_en_in(ext_set_en_in), .index_base_in(index_base_in), .mem_rdata_in(mem_rdata_in),
    .pc_out(pc_out), .flush_out(flush_out), .status_we_out(status_we_out), .mem_out(mem_out));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task test_done;
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (e !== s) begin
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
      n_mismatch++;
    end
  endtask

  // inputs change 1 ns after an edge; outputs are read one edge later
  task put(input logic [15:0] w, input logic v);
    instr_in = w;
    instr_valid_in = v;
    @(posedge clk_sys_in);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task branch(input logic [10:0] n);
    exp_pc = exp_pc + 21'h000002 + {{9{n[10]}}, n, 1'b0};
    put({5'h1A, n}, 1'b1);
    chk("pc", exp_pc, pc_out);
    chk("flush", 1, flush_out);
    chk("status_we", 0, status_we_out);
    put(16'h8123, 1'b1);
    chk("pc flush", exp_pc, pc_out);
    chk("wr flush", 0, mem_out.wr);
    chk("flush off", 0, flush_out);
  endtask

  task bitset(input logic [2:0] b, input logic a, input logic [7:0] f, input logic ext,
              input logic [11:0] ea);
    ext_set_en_in = ext;
    mem_rdata_in = f ^ 8'h5A;
    exp_pc = exp_pc + 21'h000002;
    put({4'h8, b, a, f}, 1'b1);
    chk("wr", 1, mem_out.wr);
    chk("rd", 1, mem_out.rd);
    chk("addr", ea, mem_out.addr);
    chk("wdata", (f ^ 8'h5A) | (8'h01 << b), mem_out.wdata);
    chk("pc bs", exp_pc, pc_out);
    chk("status_we bs", 0, status_we_out);
  endtask

  task other_words;
    exp_pc = exp_pc + 21'h000002;
    put(16'h0000, 1'b1);
    chk("pc other", exp_pc, pc_out);
    chk("flush other", 0, flush_out);
    put({5'h1A, 11'h123}, 1'b0);
    chk("pc held", exp_pc, pc_out);
    chk("flush held", 0, flush_out);
    chk("rd held", 0, mem_out.rd);
  endtask

  // reset is raised 1 ns after the edge that takes a branch, in its flush cycle, then a branch at the first edge after release
  task reset_mid;
    put({5'h1A, 11'h005}, 1'b1);
    rst_in = 1'b1;
    #1;
    chk("pc rst", 0, pc_out);
    chk("flush rst", 0, flush_out);
    chk("wr rst", 0, mem_out.wr);
    @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    exp_pc = '0;
    branch(11'h001);
  endtask

  initial begin
    n_mismatch = 0; cmp_count = 0; cycles = 0; exp_pc = '0;
    rst_in = 1'b1; instr_valid_in = 1'b0; instr_in = 16'h0000; ext_set_en_in = 1'b0;
    bank_select_register_in = 4'h5; index_base_in = 12'h100; mem_rdata_in = 8'h00;
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk("pc reset", 0, pc_out);
    rst_in = 1'b0;
    branch(11'h3FF);
    branch(11'h400);
    bitset(3'h7, 1'b1, 8'h0A, 1'b0, 12'h50A);
    bitset(3'h0, 1'b0, 8'h5F, 1'b1, 12'h15F);
    bitset(3'h3, 1'b0, 8'h60, 1'b1, 12'h060);
    bitset(3'h5, 1'b0, 8'h80, 1'b0, 12'hF80);
    bitset(3'h2, 1'b0, 8'h10, 1'b0, 12'h010);
    bitset(3'h1, 1'b1, 8'h20, 1'b1, 12'h520);
    other_words;
    reset_mid;
    put(16'h0000, 1'b0);
    chk("wr idle", 0, mem_out.wr);
    chk("rd idle", 0, mem_out.rd);
    chk("pc idle", exp_pc, pc_out);
    test_done;
  end
endmodule
